//--- src/asp_ctrl.sv
module asp_ctrl
    import asp_pkg::*;
#(
    parameter int RESET_WAIT_CYC = ASP_RESET_WAIT_CYC,
    parameter int PERIOD_CYC     = ASP_PWM_PERIOD_CYC
) (
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    asp_link_if.ctrl        link,
    input  wire logic [3:0] addr,
    input  wire logic [31:0] wdata,
    input  wire logic       wr_stb,
    input  wire logic       rd_stb,
    output logic [31:0]     rdata
);
    localparam int PW = $clog2(PERIOD_CYC);
    localparam int WW = $clog2(RESET_WAIT_CYC + 1);
    typedef enum logic [1:0] {ASP_C_OFF, ASP_C_STREAM, ASP_C_RUN, ASP_C_STOP} asp_cst_t;
    ////////////////////////////////////////////////////////////////////////////
    asp_cst_t    st_reg;
    logic        enable_reg;
    logic [7:0]  duty_reg;
    logic [PW-1:0] ph_reg;
    logic [WW-1:0] wait_reg;
    logic        pwm_reg;
    logic        rst_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  sd_s_reg;
    logic [1:0]  ow_s_reg;

    wire wr_ctrl   = wr_stb && (addr == ASP_REG_CTRL);
    wire wait_done = (wait_reg == WW'(RESET_WAIT_CYC));
    wire streaming = (st_reg != ASP_C_OFF);
    wire [PW-1:0] duty_cmp = PW'(duty_reg);
    // Decoded status pair
    wire [1:0] stat = {!ow_s_reg[1], !sd_s_reg[1]};
    wire [31:0] rd_mux = (addr == ASP_REG_CTRL)   ? {16'h0, duty_reg, 7'h0, enable_reg} :
                         (addr == ASP_REG_STATUS) ? {26'h0, st_reg, 2'h0, stat} : 32'h0;

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            enable_reg <= 1'b0;
            duty_reg   <= ASP_DUTY_RESET;
            rdata_reg  <= 32'h0;
            sd_s_reg   <= 2'h3;
            ow_s_reg   <= 2'h3;
        end else begin
            if (wr_ctrl) begin
                enable_reg <= wdata[ASP_CTRL_ENABLE_BIT];
                duty_reg   <= wdata[ASP_CTRL_DUTY_LSB +: 8];
            end
            rdata_reg <= rd_stb ? rd_mux : 32'h0;
            sd_s_reg  <= {sd_s_reg[0], link.fault_flag_n};
            ow_s_reg  <= {ow_s_reg[0], link.temp_warn_n};
        end
    end

    // Sequencer: stream PWM, wait, then release; reset first on stop
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg   <= ASP_C_OFF;
            wait_reg <= '0;
            rst_reg  <= 1'b0;
        end else begin
            case (st_reg)
                ASP_C_OFF: begin
                    rst_reg  <= 1'b0;
                    wait_reg <= '0;
                    if (enable_reg) st_reg <= ASP_C_STREAM;
                end
                ASP_C_STREAM: begin
                    if (!enable_reg) begin
                        st_reg <= ASP_C_STOP;
                    end else if (wait_done) begin
                        rst_reg <= 1'b1;                       // [RULE2] [RULE3]
                        st_reg  <= ASP_C_RUN;
                    end else begin
                        wait_reg <= wait_reg + WW'(1);
                    end
                end
                ASP_C_RUN: begin
                    if (!enable_reg) begin
                        rst_reg <= 1'b0;                       // [RULE5]
                        st_reg  <= ASP_C_STOP;
                    end
                end
                ASP_C_STOP: st_reg <= ASP_C_OFF;
                default:    st_reg <= ASP_C_OFF;
            endcase
        end
    end

    // Phase 0 forced low so PWM is never a constant high
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ph_reg  <= '0;
            pwm_reg <= 1'b0;
        end else begin
            ph_reg  <= (ph_reg == PW'(PERIOD_CYC - 1)) ? '0 : ph_reg + PW'(1);
            pwm_reg <= streaming && (ph_reg < duty_cmp) && (ph_reg != '0); // [RULE4]
        end
    end

    assign link.pwm_input   = pwm_reg;
    assign link.reset_ctl_n = rst_reg;
    assign rdata            = rdata_reg;
endmodule

//--- src/asp_link_if.sv
interface asp_link_if;
    logic pwm_input;
    logic reset_ctl_n;
    logic fault_flag_n_o;
    logic fault_flag_n_oe;
    logic temp_warn_n_o;
    logic temp_warn_n_oe;
    // Open-drain wires with internal pullup
    wire  fault_flag_n = fault_flag_n_oe ? fault_flag_n_o : 1'b1;
    wire  temp_warn_n  = temp_warn_n_oe ? temp_warn_n_o : 1'b1;
    modport stage (
        input  pwm_input, reset_ctl_n,
        output fault_flag_n_o, fault_flag_n_oe, temp_warn_n_o, temp_warn_n_oe
    );
    modport ctrl (
        output pwm_input, reset_ctl_n,
        input  fault_flag_n, temp_warn_n
    );
endinterface

//--- src/asp_pkg.sv
package asp_pkg;
    // Protection mode strap codes {hi, lo}
    localparam logic [1:0] ASP_MODE_AUTORECOVERY = 2'h0;
    localparam logic [1:0] ASP_MODE_LATCHING     = 2'h1;
    localparam logic [1:0] ASP_MODE_PROT_OFF     = 2'h2;
    localparam logic [1:0] ASP_MODE_RESERVED     = 2'h3;
    localparam logic       ASP_OUT_BRIDGE_TIED   = 1'h0;
    // Autorecovery length in PWM cycles
    localparam int         ASP_AR_CYCLES         = 512;
    // Controller timing, microseconds and clock
    localparam int         ASP_CLK_MHZ           = 50;
    localparam int         ASP_RESET_MIN_US      = 800;
    localparam int         ASP_RESET_WAIT_US     = 1000;
    localparam int         ASP_RESET_MIN_CYC     = ASP_RESET_MIN_US * ASP_CLK_MHZ;
    localparam int         ASP_RESET_WAIT_CYC    = ASP_RESET_WAIT_US * ASP_CLK_MHZ;
    // PWM period at 50 MHz: 125..142 cycles (350..400 kHz); 128 gives 390.6 kHz
    localparam int         ASP_PWM_PERIOD_CYC    = 128;
    // Host register offsets
    localparam logic [3:0] ASP_REG_CTRL          = 4'h0;
    localparam logic [3:0] ASP_REG_STATUS        = 4'h4;
    localparam int         ASP_CTRL_ENABLE_BIT   = 0;
    localparam int         ASP_CTRL_DUTY_LSB     = 8;
    localparam logic [7:0] ASP_DUTY_RESET        = 8'h40;
    typedef enum logic [1:0] {
        ASP_ST_OK,
        ASP_ST_WARN,
        ASP_ST_OCUV,
        ASP_ST_OTE
    } asp_status_t;
endpackage

//--- src/asp_recovery_cnt.sv
module asp_recovery_cnt
    import asp_pkg::*;
#(
    parameter int N = ASP_AR_CYCLES
) (
    input  wire logic sys_clk,
    input  wire logic arst_n,
    input  wire logic clear,
    input  wire logic start,
    input  wire logic pwm_rise,
    output logic      half_reached,
    output logic      full_reached,
    output logic      busy
);
    localparam int W = $clog2(N) + 1;
    logic [W-1:0] cnt_reg;
    logic         run_reg;
    wire          at_end = (cnt_reg == W'(N));

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= '0;
            run_reg <= 1'b0;
        end else if (clear || at_end) begin // [RULE21]
            cnt_reg <= '0;
            run_reg <= 1'b0;
        end else if (start && !run_reg) begin
            cnt_reg <= '0;
            run_reg <= 1'b1;
        end else if (run_reg && pwm_rise) begin // [RULE15]
            cnt_reg <= cnt_reg + W'(1);
        end
    end

    assign half_reached = run_reg && (cnt_reg >= W'(N / 2));
    assign full_reached = run_reg && at_end;
    assign busy         = run_reg;
endmodule

//--- src/asp_stage.sv
// Operation
// RULE1 - Reset low: all transistors off, Hi-Z
// RULE2 - Controller holds reset low 800 us, 1 ms
// RULE3 - Release only with PWM at 350-400 kHz
// RULE4 - PWM never stuck high while enabled
// RULE5 - Power-down: reset low before PWM stops
// RULE6 - Fault flag low in protection, else high
// RULE7 - Reset low releases fault flag high
// RULE8 - Warning low above 125 C, shared
// RULE9 - Status pair decodes OVER_TEMP_ERROR, warn, OC/UV, normal
// RULE10 - Any error sets latch, forces Hi-Z
// RULE11 - Latch clears at reset fall; resume when clean
// RULE12 - Reset low also mutes switching
// RULE13 - Overcurrent per transistor is an error
// RULE14 - Gate supply undervoltage is an error
// RULE15 - Recovery delay counts PWM input cycles
// RULE16 - Autorecovery: clear at n/2, resume at n
// RULE17 - Latching mode: Hi-Z until reset toggles
// RULE18 - Protection-off mode ignores all detections
// RULE19 - Straps select autorecovery, latching, off
// RULE20 - Output strap 0 selects bridge-tied
// RULE21 - Straps static; counter on PWM rise
module asp_stage
    import asp_pkg::*;
#(
    parameter int N_BRIDGES = 2,
    parameter int AR_CYCLES = ASP_AR_CYCLES
) (
    input  wire logic                   sys_clk,
    input  wire logic                   arst_n,
    asp_link_if.stage                   link,
    input  wire logic                   prot_mode_strap_hi,
    input  wire logic                   prot_mode_strap_lo,
    input  wire logic                   output_mode_strap,
    input  wire logic [N_BRIDGES*2-1:0] overcurrent_fault,
    input  wire logic                   undervoltage_fault,
    input  wire logic                   over_temp_error,
    input  wire logic                   temp_over_125c,
    output logic [N_BRIDGES-1:0]        hs_gate_on,
    output logic [N_BRIDGES-1:0]        ls_gate_on,
    output logic                        bridge_hiz,
    output logic                        prot_latched
);
    ////////////////////////////////////////////////////////////////////////////
    logic [1:0]           mode_reg;
    logic                 btl_ok_reg;
    logic                 strap_taken_reg;
    logic                 latch_reg;
    logic                 ar_hold_reg;
    logic                 rst_d_reg;
    logic                 pwm_d_reg;
    logic                 fault_o_reg;
    logic                 fault_oe_reg;
    logic                 warn_oe_reg;
    logic                 warn_o_reg;
    logic                 hiz_reg;
    logic [N_BRIDGES-1:0] hs_reg;
    logic [N_BRIDGES-1:0] ls_reg;

    // Edge detectors reset to the idle pin levels: no false edge
    wire rst_low    = !link.reset_ctl_n;
    wire rst_fall   = rst_d_reg && rst_low;
    wire pwm_rise   = link.pwm_input && !pwm_d_reg;
    // Straps read as {hi, lo}; anything but bridge-tied keeps the stage off
    wire [1:0] strap_code = {prot_mode_strap_hi, prot_mode_strap_lo};
    wire       strap_btl  = (output_mode_strap == ASP_OUT_BRIDGE_TIED);
    wire mode_ar    = (mode_reg == ASP_MODE_AUTORECOVERY);   // [RULE19]
    // Reserved strap code falls through to latching: the safest reading
    wire mode_off   = (mode_reg == ASP_MODE_PROT_OFF);
    // Every transistor and the shared senses feed one latch
    wire any_oc     = |overcurrent_fault;                     // [RULE13]
    wire raw_error  = any_oc || undervoltage_fault || over_temp_error; // [RULE14]
    wire error_evt  = raw_error && !mode_off;                 // [RULE18]
    wire ar_half;
    wire ar_full;
    wire ar_busy;

    // One recovery counter serves both bridges
    asp_recovery_cnt #(.N(AR_CYCLES)) u_ar (
        .sys_clk      (sys_clk),
        .arst_n       (arst_n),
        .clear        (rst_low),
        .start        (mode_ar && latch_reg),
        .pwm_rise     (pwm_rise),
        .half_reached (ar_half),
        .full_reached (ar_full),
        .busy         (ar_busy)
    );

    // Drive allowed only with reset high, no latch, no hold, BRIDGE_TIED_OUTPUT strap
    wire run_ok     = !rst_low && !latch_reg && !ar_hold_reg && btl_ok_reg
                      && !error_evt;                          // [RULE20]
    wire hiz_next   = !run_ok;
    wire hold_set   = mode_ar && ar_busy && ar_half;
    wire hold_clr   = rst_low || ar_full;
    // Fault pin is masked while reset is low; the warning pin never is
    wire fault_oe_next = !rst_low && latch_reg;
    wire warn_oe_next  = temp_over_125c || over_temp_error;
    ////////////////////////////////////////////////////////////////////////////
    // Straps caught once after reset release, then held static
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_reg        <= ASP_MODE_RESERVED;
            btl_ok_reg      <= 1'b0;
            strap_taken_reg <= 1'b0;
        end else if (!strap_taken_reg) begin
            mode_reg        <= strap_code;                     // [RULE21]
            btl_ok_reg      <= strap_btl;
            strap_taken_reg <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_d_reg <= 1'b0;
            pwm_d_reg <= 1'b0;
        end else begin
            rst_d_reg <= link.reset_ctl_n;
            pwm_d_reg <= link.pwm_input;
        end
    end

    // New error wins over any clear in the same cycle
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            latch_reg <= 1'b0;
        end else if (error_evt && strap_taken_reg) begin
            latch_reg <= 1'b1;                                 // [RULE10]
        end else if (rst_fall) begin
            latch_reg <= 1'b0;                                 // [RULE11] [RULE17]
        end else if (mode_ar && ar_half) begin
            latch_reg <= 1'b0;                                 // [RULE16]
        end
    end

    // Hold Hi-Z from n/2 until n, like reset low then high
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ar_hold_reg <= 1'b0;
        end else if (hold_clr) begin
            ar_hold_reg <= 1'b0;                               // [RULE16]
        end else if (hold_set) begin
            ar_hold_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Hi-Z until every drive condition holds
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            hiz_reg <= 1'b1;
        end else begin
            hiz_reg <= hiz_next;                               // [RULE1] [RULE12]
        end
    end

    // Gate drive follows PWM; non-overlap left to the analog driver
    genvar b;
    generate
        for (b = 0; b < N_BRIDGES; b = b + 1) begin : g_bridge
            wire hs_next = run_ok && link.pwm_input;
            wire ls_next = run_ok && !link.pwm_input;
            always_ff @(posedge sys_clk or negedge arst_n) begin
                if (!arst_n) begin
                    hs_reg[b] <= 1'b0;
                    ls_reg[b] <= 1'b0;
                end else begin
                    hs_reg[b] <= hs_next;
                    ls_reg[b] <= ls_next;
                end
            end
        end
    endgenerate

    // Open-drain: enable means pulling low
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            fault_o_reg  <= 1'b0;
            fault_oe_reg <= 1'b0;
        end else begin
            fault_o_reg  <= 1'b0;
            fault_oe_reg <= fault_oe_next;                     // [RULE6] [RULE7] [RULE9]
        end
    end

    // Shared temperature sense; the level driven is always low
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            warn_o_reg  <= 1'b0;
            warn_oe_reg <= 1'b0;
        end else begin
            warn_o_reg  <= 1'b0;
            warn_oe_reg <= warn_oe_next;                       // [RULE8] [RULE9]
        end
    end

    assign link.fault_flag_n_o  = fault_o_reg;
    assign link.fault_flag_n_oe = fault_oe_reg;
    assign link.temp_warn_n_o   = warn_o_reg;
    assign link.temp_warn_n_oe  = warn_oe_reg;
    assign hs_gate_on           = hs_reg;
    assign ls_gate_on           = ls_reg;
    assign bridge_hiz           = hiz_reg;
    assign prot_latched         = latch_reg;
endmodule

//--- test/asp_link_checker.sv
module asp_link_checker #(
    parameter int WAIT_CYC   = 20,
    parameter int PERIOD_CYC = 128
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic pwm_input,
    input wire logic reset_ctl_n,
    input wire logic fault_flag_n_o,
    input wire logic fault_flag_n_oe,
    input wire logic temp_warn_n_o,
    input wire logic temp_warn_n_oe,
    input wire logic fault_flag_n,
    input wire logic temp_warn_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] low_cnt_reg;
    logic [7:0]  rise_cnt_reg;
    logic [15:0] stable_cnt_reg;
    ////////////////////////////////////////////////////////////////////////////////
    // Wraps only after far longer than any run
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            low_cnt_reg    <= 16'h0000;
            rise_cnt_reg   <= 8'h00;
            stable_cnt_reg <= 16'h0000;
        end else begin
            low_cnt_reg    <= reset_ctl_n ? 16'h0000 : low_cnt_reg + 16'h0001;
            rise_cnt_reg   <= reset_ctl_n ? 8'h00 : rise_cnt_reg + {7'h00, $rose(pwm_input)};
            stable_cnt_reg <= $changed(pwm_input) ? 16'h0000 : stable_cnt_reg + 16'h0001;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    AST_FAULT_RELEASED_IN_RESET: assert property (
        !reset_ctl_n |=> fault_flag_n) else $error("fault flag low while reset low");
    AST_FAULT_PULLS_LOW_ONLY: assert property (
        fault_flag_n_oe |-> !fault_flag_n_o) else $error("fault pin driven high");
    AST_WARN_PULLS_LOW_ONLY: assert property (
        temp_warn_n_oe |-> !temp_warn_n_o) else $error("warning pin driven high");
    AST_FAULT_NEEDS_RESET_HIGH: assert property (
        $fell(fault_flag_n) |-> $past(reset_ctl_n)) else $error("fault flag fell in reset");
    AST_RESET_WAIT_HELD: assert property (
        $rose(reset_ctl_n) |-> int'(low_cnt_reg) >= WAIT_CYC) else $error("reset low too short");
    AST_STREAM_BEFORE_RELEASE: assert property (
        $rose(reset_ctl_n) |-> rise_cnt_reg != 8'h00) else $error("reset released, no pwm");
    AST_PWM_NEVER_STUCK_HIGH: assert property (
        pwm_input |-> int'(stable_cnt_reg) < PERIOD_CYC) else $error("pwm stuck high");
    AST_PWM_VALID_WHILE_RUN: assert property (
        reset_ctl_n |-> int'(stable_cnt_reg) < PERIOD_CYC) else $error("pwm stopped in run");
    cover property ($fell(fault_flag_n));
    cover property ($fell(temp_warn_n));
    cover property ($rose(reset_ctl_n));
endmodule

//--- test/test_amp_stage_protection_ctrl.sv
module test_amp_stage_protection_ctrl
    import asp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk, arst_n, prot_mode_strap_hi, prot_mode_strap_lo, output_mode_strap;
    logic [3:0]  overcurrent_fault, addr;
    logic        undervoltage_fault, over_temp_error, temp_over_125c, wr_stb, rd_stb;
    logic [1:0]  hs_gate_on, ls_gate_on;
    logic        bridge_hiz, prot_latched;
    logic [31:0] wdata, rdata;
    int          bad_count, checks_done, cyc;
    asp_link_if u_asp_link_if ();
    asp_stage #(.N_BRIDGES(2), .AR_CYCLES(8)) u_asp_stage (.sys_clk, .arst_n,
        .link(u_asp_link_if), .prot_mode_strap_hi, .prot_mode_strap_lo, .output_mode_strap,
        .overcurrent_fault, .undervoltage_fault, .over_temp_error, .temp_over_125c,
        .hs_gate_on, .ls_gate_on, .bridge_hiz, .prot_latched);
    asp_ctrl #(.RESET_WAIT_CYC(256), .PERIOD_CYC(ASP_PWM_PERIOD_CYC)) u_asp_ctrl (.sys_clk,
        .arst_n, .link(u_asp_link_if), .addr, .wdata, .wr_stb, .rd_stb, .rdata);
    asp_link_checker #(.WAIT_CYC(256), .PERIOD_CYC(ASP_PWM_PERIOD_CYC)) u_asp_link_checker (
        .sys_clk, .arst_n, .pwm_input(u_asp_link_if.pwm_input),
        .reset_ctl_n(u_asp_link_if.reset_ctl_n), .fault_flag_n_o(u_asp_link_if.fault_flag_n_o),
        .fault_flag_n_oe(u_asp_link_if.fault_flag_n_oe), .temp_warn_n_o(u_asp_link_if.temp_warn_n_o),
        .temp_warn_n_oe(u_asp_link_if.temp_warn_n_oe), .fault_flag_n(u_asp_link_if.fault_flag_n),
        .temp_warn_n(u_asp_link_if.temp_warn_n));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 60000) begin
            bad_count++;
            final_report();
        end
    end
    task automatic final_report();
        $display("Checks %0d, errors %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr <= a; wdata <= d; wr_stb <= 1'b1;
        @(posedge sys_clk);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        addr <= a; rd_stb <= 1'b1;
        @(posedge sys_clk);
        rd_stb <= 1'b0;
        #1 d = rdata;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Enable, then wait for the sequencer to let go of reset
    task automatic run_up();
        wr(ASP_REG_CTRL, 32'h00004001);
        cycles(6);
        chk({hs_gate_on, ls_gate_on, bridge_hiz}, 8'h01);
        for (int i = 0; i < 400 && u_asp_link_if.reset_ctl_n !== 1'b1; i++) cycles(1);
        chk(u_asp_link_if.reset_ctl_n, 8'h01);
        cycles(4);
    endtask
    task automatic boot(input logic [1:0] mode, input logic om);
        @(posedge sys_clk);
        arst_n <= 1'b0;
        {prot_mode_strap_hi, prot_mode_strap_lo} <= mode;
        output_mode_strap <= om;
        cycles(5);
        chk({hs_gate_on, ls_gate_on, bridge_hiz}, 8'h01);
        chk(u_asp_link_if.fault_flag_n, 8'h01);
        @(posedge sys_clk);
        arst_n <= 1'b1;
        run_up();
    endtask
    task automatic set_err(input int k, input logic v);
        @(posedge sys_clk);
        overcurrent_fault  <= (v && k < 4) ? (4'h1 << k) : 4'h0;
        undervoltage_fault <= v && k == 4;
        over_temp_error    <= v && k == 5;
        temp_over_125c     <= v && k == 5;
    endtask
    // Strap 11 behaves as latching, so both share this task
    task automatic t_latch(input logic [1:0] mode);
        logic [31:0] d;
        boot(mode, 1'b0);
        for (int k = 0; k < 6; k++) begin
            chk({bridge_hiz, u_asp_link_if.fault_flag_n}, 8'h01);
            set_err(k, 1'b1);
            cycles(5);
            chk({prot_latched, bridge_hiz}, 8'h03);
            chk(u_asp_link_if.fault_flag_n, 8'h00);
            chk(u_asp_link_if.temp_warn_n, (k != 5));
            rd(ASP_REG_STATUS, d);
            chk(d[1:0], {(k == 5), 1'b1});
            set_err(k, 1'b0);
            cycles(20);
            chk({prot_latched, bridge_hiz}, 8'h03);
            wr(ASP_REG_CTRL, 32'h00000000);
            cycles(4);
            chk({prot_latched, u_asp_link_if.fault_flag_n}, 8'h01);
            run_up();
        end
    endtask
    task automatic rises(input int n);
        repeat (n) @(posedge u_asp_link_if.pwm_input);
        cycles(1);
    endtask
    task automatic t_auto();
        boot(ASP_MODE_AUTORECOVERY, 1'b0);
        set_err(4, 1'b1);
        cycles(3);
        set_err(4, 1'b0);
        rises(2);
        chk({prot_latched, bridge_hiz}, 8'h03);
        rises(4);
        chk({prot_latched, bridge_hiz}, 8'h01);
        rises(4);
        cycles(3);
        chk({prot_latched, bridge_hiz}, 8'h00);
        @(posedge u_asp_link_if.pwm_input);
        cycles(2);
        chk({hs_gate_on, ls_gate_on}, 8'h0C);
        @(negedge u_asp_link_if.pwm_input);
        cycles(2);
        chk({hs_gate_on, ls_gate_on}, 8'h03);
    endtask
    task automatic t_off_warn();
        logic [31:0] d;
        boot(ASP_MODE_PROT_OFF, 1'b0);
        for (int k = 0; k < 6; k++) begin
            set_err(k, 1'b1);
            cycles(4);
            chk({prot_latched, bridge_hiz, u_asp_link_if.fault_flag_n}, 8'h01);
            set_err(k, 1'b0);
        end
        @(posedge sys_clk);
        temp_over_125c <= 1'b1;
        cycles(5);
        chk({u_asp_link_if.temp_warn_n, u_asp_link_if.fault_flag_n, bridge_hiz}, 8'h02);
        rd(ASP_REG_STATUS, d);
        chk(d[5:0], 8'h22);
        rd(4'h8, d);
        chk(d[7:0], 8'h00);
        @(posedge sys_clk);
        temp_over_125c <= 1'b0;
        cycles(4);
        chk(u_asp_link_if.temp_warn_n, 8'h01);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        arst_n = 1'b0; prot_mode_strap_hi = 1'b0; prot_mode_strap_lo = 1'b0;
        output_mode_strap = 1'b0; overcurrent_fault = 4'h0; undervoltage_fault = 1'b0;
        over_temp_error = 1'b0; temp_over_125c = 1'b0; addr = 4'h0; wdata = 32'h00000000;
        wr_stb = 1'b0; rd_stb = 1'b0; bad_count = 0; checks_done = 0; cyc = 0;
        t_latch(ASP_MODE_LATCHING);
        t_latch(ASP_MODE_RESERVED);
        t_auto();
        t_off_warn();
        boot(ASP_MODE_LATCHING, 1'b1);
        chk(bridge_hiz, 8'h01);
        final_report();
    end
endmodule
